// >>> logic/initial_speed_detect_config_regs.vh
// Offsets, field positions, reset value and table codes of the
// initial-speed-detect configuration word.
// Assumes the serial host front end delivers decoded word writes and reads.
// Operation
// - All speed-detect settings share one word
// - Bits 25..22 set forward resync speed
// - Bit 21 set means low-side brake; 0 reserved
// - Bit 20 picks time or current+time exit
// - Bits 16..13 set brake duration
// - Bits 8..6 set stationary back-EMF threshold
// - Bits 5..2 set reverse handoff speed
// - Bits 1..0 set reverse open-loop current
`ifndef INITIAL_SPEED_DETECT_CONFIG_REGS_VH
`define INITIAL_SPEED_DETECT_CONFIG_REGS_VH

// Register offset and reset value
`define ISDC_OFFSET 8'h80
`define ISDC_RESET 32'h00000000
`define ISDC_WRITABLE_MASK 32'h7FFFFFFF

// Single-bit enables above the detect fields
`define ISDC_DETECT_EN_BIT 30
`define ISDC_BRAKE_EN_BIT 29
`define ISDC_COAST_EN_BIT 28
`define ISDC_REVERSE_EN_BIT 27
`define ISDC_RESYNC_EN_BIT 26

// Field positions
`define ISDC_RESYNC_THR_MSB 25
`define ISDC_RESYNC_THR_LSB 22
`define ISDC_BRAKE_STYLE_BIT 21
`define ISDC_BRAKE_EXIT_BIT 20
`define ISDC_BRAKE_CURR_MSB 19
`define ISDC_BRAKE_CURR_LSB 17
`define ISDC_BRAKE_DUR_MSB 16
`define ISDC_BRAKE_DUR_LSB 13
`define ISDC_COAST_DUR_MSB 12
`define ISDC_COAST_DUR_LSB 9
`define ISDC_STAT_THR_MSB 8
`define ISDC_STAT_THR_LSB 6
`define ISDC_HANDOFF_MSB 5
`define ISDC_HANDOFF_LSB 2
`define ISDC_REV_CURR_MSB 1
`define ISDC_REV_CURR_LSB 0

// Reserved encodings
`define ISDC_BRAKE_STYLE_LOW_SIDE 1'h1
`define ISDC_BRAKE_CURR_RESERVED 3'h7

`endif

// >>> logic/isd_duration_decode.v
// Duration code to milliseconds, shared by brake and coast intervals.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`include "initial_speed_detect_config_regs.vh"

module isd_duration_decode (
  input wire [3:0] code_i,
  output reg [13:0] duration_ms_o
);

  // Sixteen-step table, 10 ms up to 15 s
  always @* begin
    case (code_i)
      4'h0: duration_ms_o = 14'd10;
      4'h1: duration_ms_o = 14'd50;
      4'h2: duration_ms_o = 14'd100;
      4'h3: duration_ms_o = 14'd200;
      4'h4: duration_ms_o = 14'd300;
      4'h5: duration_ms_o = 14'd400;
      4'h6: duration_ms_o = 14'd500;
      4'h7: duration_ms_o = 14'd750;
      4'h8: duration_ms_o = 14'd1000;
      4'h9: duration_ms_o = 14'd2000;
      4'hA: duration_ms_o = 14'd3000;
      4'hB: duration_ms_o = 14'd4000;
      4'hC: duration_ms_o = 14'd5000;
      4'hD: duration_ms_o = 14'd7500;
      4'hE: duration_ms_o = 14'd10000;
      default: duration_ms_o = 14'd15000;
    endcase
  end

endmodule

// >>> logic/initial_speed_detect_config.v
// Initial-speed-detect configuration word with decoded settings for the
// motor start sequencer.
// Assumes writes and reads arrive already decoded from the serial host
// as word-wide strobes with a byte offset, synchronous to clk_i.
`timescale 1ns/1ps
`include "initial_speed_detect_config_regs.vh"

module initial_speed_detect_config (
  input wire clk_i,
  input wire rst_i,
  input wire wr_en_i,
  input wire [7:0] wr_addr_i,
  input wire [31:0] wr_data_i,
  input wire rd_en_i,
  input wire [7:0] rd_addr_i,
  output reg [31:0] rd_data_o,
  output reg rd_valid_o,
  output reg rd_hit_o,
  output reg [31:0] config_word_o,
  output reg detect_en_o,
  output reg brake_en_o,
  output reg coast_en_o,
  output reg reverse_en_o,
  output reg resync_en_o,
  output reg [3:0] forward_resync_speed_threshold_o,
  output reg brake_style_select_o,
  output reg brake_exit_condition_o,
  output reg [2:0] brake_current_threshold_o,
  output reg [3:0] brake_duration_o,
  output reg [3:0] coast_duration_o,
  output reg [2:0] stationary_backemf_threshold_o,
  output reg [3:0] reverse_handoff_speed_o,
  output reg [1:0] reverse_open_loop_current_limit_o,
  output reg [9:0] resync_speed_permille_o,
  output reg brake_exit_uses_current_o,
  output reg [5:0] brake_current_sixteenths_o,
  output reg [13:0] brake_duration_ms_o,
  output reg [13:0] coast_duration_ms_o,
  output reg [10:0] stationary_backemf_mv_o,
  output reg [9:0] handoff_speed_permille_o,
  output reg [5:0] reverse_current_sixteenths_o,
  output reg reserved_setting_o
);

  reg [31:0] config_reg;
  reg [31:0] config_next;
  wire [13:0] brake_ms;
  wire [13:0] coast_ms;

  // Forward resync speed, per mille of full speed
  function [9:0] resync_permille;
    input [3:0] code;
    begin
      if (code < 4'hC) begin
        resync_permille = 10'd50 * ({6'h00, code} + 10'd1);
      end else begin
        resync_permille = 10'd700 + 10'd100 * {6'h00, code - 4'hC};
      end
    end
  endfunction

  // Handoff speed, per mille of full speed
  function [9:0] handoff_permille;
    input [3:0] code;
    begin
      case (code)
        4'h0: handoff_permille = 10'd25;
        4'h1: handoff_permille = 10'd50;
        4'h2: handoff_permille = 10'd75;
        4'h3: handoff_permille = 10'd100;
        4'h4: handoff_permille = 10'd125;
        4'h5: handoff_permille = 10'd150;
        4'h6: handoff_permille = 10'd200;
        4'h7: handoff_permille = 10'd250;
        4'h8: handoff_permille = 10'd300;
        4'h9: handoff_permille = 10'd400;
        4'hA: handoff_permille = 10'd500;
        4'hB: handoff_permille = 10'd600;
        4'hC: handoff_permille = 10'd700;
        4'hD: handoff_permille = 10'd800;
        4'hE: handoff_permille = 10'd900;
        default: handoff_permille = 10'd1000;
      endcase
    end
  endfunction

  // Brake current in 1/16 A; reserved code reads as zero current
  function [5:0] brake_curr_sixteenths;
    input [2:0] code;
    begin
      case (code)
        3'h0: brake_curr_sixteenths = 6'd1;
        3'h1: brake_curr_sixteenths = 6'd2;
        3'h2: brake_curr_sixteenths = 6'd3;
        3'h3: brake_curr_sixteenths = 6'd5;
        3'h4: brake_curr_sixteenths = 6'd10;
        3'h5: brake_curr_sixteenths = 6'd20;
        3'h6: brake_curr_sixteenths = 6'd40;
        default: brake_curr_sixteenths = 6'd0;
      endcase
    end
  endfunction

  // Stationary back-EMF threshold in millivolts
  function [10:0] stat_mv;
    input [2:0] code;
    begin
      case (code)
        3'h0: stat_mv = 11'd50;
        3'h1: stat_mv = 11'd75;
        3'h2: stat_mv = 11'd100;
        3'h3: stat_mv = 11'd250;
        3'h4: stat_mv = 11'd500;
        3'h5: stat_mv = 11'd750;
        3'h6: stat_mv = 11'd1000;
        default: stat_mv = 11'd1500;
      endcase
    end
  endfunction

  // Reverse open-loop current in 1/16 A
  function [5:0] rev_curr_sixteenths;
    input [1:0] code;
    begin
      case (code)
        2'h0: rev_curr_sixteenths = 6'd15;
        2'h1: rev_curr_sixteenths = 6'd25;
        2'h2: rev_curr_sixteenths = 6'd35;
        default: rev_curr_sixteenths = 6'd50;
      endcase
    end
  endfunction

  // one shared word
  // Top bit is reserved and always stored as zero
  always @* begin
    config_next = config_reg;
    if (wr_en_i && (wr_addr_i == `ISDC_OFFSET)) begin
      config_next = wr_data_i & `ISDC_WRITABLE_MASK;
    end
  end

  // Word storage
  always @(posedge clk_i) begin
    if (rst_i) begin
      config_reg <= `ISDC_RESET;
    end else begin
      config_reg <= config_next;
    end
  end

  isd_duration_decode u_brake_dur (
    .code_i(config_next[`ISDC_BRAKE_DUR_MSB:`ISDC_BRAKE_DUR_LSB]),
    .duration_ms_o(brake_ms)
  );

  isd_duration_decode u_coast_dur (
    .code_i(config_next[`ISDC_COAST_DUR_MSB:`ISDC_COAST_DUR_LSB]),
    .duration_ms_o(coast_ms)
  );

  // Read port answers one cycle later; unmapped offsets read zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_o <= 32'h00000000;
      rd_valid_o <= 1'b0;
      rd_hit_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_en_i;
      rd_hit_o <= rd_en_i && (rd_addr_i == `ISDC_OFFSET);
      if (rd_en_i && (rd_addr_i == `ISDC_OFFSET)) begin
        rd_data_o <= config_reg;
      end else begin
        rd_data_o <= 32'h00000000;
      end
    end
  end

  // Raw fields and decoded values follow the stored word in the same
  // cycle, decoded from the next value so nothing lags the word.
  always @(posedge clk_i) begin
    if (rst_i) begin
      config_word_o <= `ISDC_RESET;
      detect_en_o <= 1'b0;
      brake_en_o <= 1'b0;
      coast_en_o <= 1'b0;
      reverse_en_o <= 1'b0;
      resync_en_o <= 1'b0;
      forward_resync_speed_threshold_o <= 4'h0;
      brake_style_select_o <= 1'b0;
      brake_exit_condition_o <= 1'b0;
      brake_current_threshold_o <= 3'h0;
      brake_duration_o <= 4'h0;
      coast_duration_o <= 4'h0;
      stationary_backemf_threshold_o <= 3'h0;
      reverse_handoff_speed_o <= 4'h0;
      reverse_open_loop_current_limit_o <= 2'h0;
      resync_speed_permille_o <= 10'd50;
      brake_exit_uses_current_o <= 1'b0;
      brake_current_sixteenths_o <= 6'd1;
      brake_duration_ms_o <= 14'd10;
      coast_duration_ms_o <= 14'd10;
      stationary_backemf_mv_o <= 11'd50;
      handoff_speed_permille_o <= 10'd25;
      reverse_current_sixteenths_o <= 6'd15;
      reserved_setting_o <= 1'b1;
    end else begin
      config_word_o <= config_next;
      detect_en_o <= config_next[`ISDC_DETECT_EN_BIT];
      brake_en_o <= config_next[`ISDC_BRAKE_EN_BIT];
      coast_en_o <= config_next[`ISDC_COAST_EN_BIT];
      reverse_en_o <= config_next[`ISDC_REVERSE_EN_BIT];
      resync_en_o <= config_next[`ISDC_RESYNC_EN_BIT];
      forward_resync_speed_threshold_o <=
        config_next[`ISDC_RESYNC_THR_MSB:`ISDC_RESYNC_THR_LSB];
      resync_speed_permille_o <=
        resync_permille(config_next[`ISDC_RESYNC_THR_MSB:`ISDC_RESYNC_THR_LSB]);
      brake_style_select_o <= config_next[`ISDC_BRAKE_STYLE_BIT];
      brake_exit_condition_o <= config_next[`ISDC_BRAKE_EXIT_BIT];
      brake_exit_uses_current_o <= config_next[`ISDC_BRAKE_EXIT_BIT];
      brake_current_threshold_o <=
        config_next[`ISDC_BRAKE_CURR_MSB:`ISDC_BRAKE_CURR_LSB];
      brake_current_sixteenths_o <=
        brake_curr_sixteenths(config_next[`ISDC_BRAKE_CURR_MSB:`ISDC_BRAKE_CURR_LSB]);
      brake_duration_o <= config_next[`ISDC_BRAKE_DUR_MSB:`ISDC_BRAKE_DUR_LSB];
      brake_duration_ms_o <= brake_ms;
      coast_duration_o <= config_next[`ISDC_COAST_DUR_MSB:`ISDC_COAST_DUR_LSB];
      coast_duration_ms_o <= coast_ms;
      stationary_backemf_threshold_o <=
        config_next[`ISDC_STAT_THR_MSB:`ISDC_STAT_THR_LSB];
      stationary_backemf_mv_o <=
        stat_mv(config_next[`ISDC_STAT_THR_MSB:`ISDC_STAT_THR_LSB]);
      reverse_handoff_speed_o <= config_next[`ISDC_HANDOFF_MSB:`ISDC_HANDOFF_LSB];
      handoff_speed_permille_o <=
        handoff_permille(config_next[`ISDC_HANDOFF_MSB:`ISDC_HANDOFF_LSB]);
      reverse_open_loop_current_limit_o <=
        config_next[`ISDC_REV_CURR_MSB:`ISDC_REV_CURR_LSB];
      reverse_current_sixteenths_o <=
        rev_curr_sixteenths(config_next[`ISDC_REV_CURR_MSB:`ISDC_REV_CURR_LSB]);
      // flag reserved brake style or reserved brake current
      // Stored as written; the sequencer decides how to react, since
      // silently rewriting the host's value would hide its mistake.
      reserved_setting_o <=
        (config_next[`ISDC_BRAKE_STYLE_BIT] != `ISDC_BRAKE_STYLE_LOW_SIDE) ||
        (config_next[`ISDC_BRAKE_CURR_MSB:`ISDC_BRAKE_CURR_LSB] ==
         `ISDC_BRAKE_CURR_RESERVED);
    end
  end

endmodule

// >>> verif/initial_speed_detect_config_properties.sv
// Checker for the initial-speed-detect configuration word.
// Assumes it is bound to the register block and sees only its ports.
`timescale 1ns/1ps
module initial_speed_detect_config_properties (
  input wire clk_i,
  input wire rst_i,
  input wire wr_en_i,
  input wire [7:0] wr_addr_i,
  input wire [31:0] wr_data_i,
  input wire rd_en_i,
  input wire [7:0] rd_addr_i,
  input wire [31:0] rd_data_o,
  input wire rd_valid_o,
  input wire rd_hit_o,
  input wire [31:0] config_word_o,
  input wire [9:0] resync_speed_permille_o,
  input wire brake_exit_uses_current_o,
  input wire reserved_setting_o,
  input wire [3:0] brake_duration_o,
  input wire [3:0] coast_duration_o,
  input wire [13:0] brake_duration_ms_o,
  input wire [13:0] coast_duration_ms_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire [3:0] rs = config_word_o[25:22];
  // Mapped write lands whole, top bit dropped
  property p_write_stores;
    wr_en_i && wr_addr_i == 8'h80 |=> config_word_o == ($past(wr_data_i) & 32'h7FFFFFFF);
  endproperty
  a_write_stores: assert property (p_write_stores) else $error("stored word differs");
  property p_word_holds;
    !(wr_en_i && wr_addr_i == 8'h80) |=> $stable(config_word_o);
  endproperty
  a_word_holds: assert property (p_word_holds) else $error("word changed unasked");
  property p_read_answer;
    rd_en_i |=> rd_valid_o && rd_hit_o == ($past(rd_addr_i) == 8'h80);
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer wrong");
  property p_read_data;
    rd_en_i && rd_addr_i == 8'h80 |=> rd_data_o == $past(config_word_o);
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data wrong");
  property p_resync_decode;
    resync_speed_permille_o == (rs < 4'hC ? 10'(50 * (rs + 1)) : 10'(700 + 100 * (rs - 12)));
  endproperty
  a_resync_decode: assert property (p_resync_decode) else $error("resync speed wrong");
  property p_reserved_flag;
    reserved_setting_o == (!config_word_o[21] || config_word_o[19:17] == 3'h7);
  endproperty
  a_reserved_flag: assert property (p_reserved_flag) else $error("reserved flag wrong");
  property p_exit_select;
    brake_exit_uses_current_o == config_word_o[20];
  endproperty
  a_exit_select: assert property (p_exit_select) else $error("brake exit wrong");
  property p_brake_field;
    brake_duration_o == config_word_o[16:13];
  endproperty
  a_brake_field: assert property (p_brake_field) else $error("brake time field wrong");
  property p_coast_same;
    coast_duration_o == brake_duration_o |-> coast_duration_ms_o == brake_duration_ms_o;
  endproperty
  a_coast_same: assert property (p_coast_same) else $error("coast table differs");
  c_write: cover property (wr_en_i && wr_addr_i == 8'h80);
  c_miss: cover property (rd_en_i && rd_addr_i != 8'h80);
  c_reserved: cover property (config_word_o[19:17] == 3'h7);
endmodule
bind initial_speed_detect_config initial_speed_detect_config_properties initial_speed_detect_config_properties_inst (.*);

// >>> verif/serial_host_model.sv
// Host side that writes and reads the configuration word.
// Assumes the block answers a read one cycle after the strobe.
`timescale 1ns/1ps
module serial_host_model (
  input wire clk_i,
  output logic wr_en_o,
  output logic [7:0] wr_addr_o,
  output logic [31:0] wr_data_o,
  output logic rd_en_o,
  output logic [7:0] rd_addr_o,
  input wire [31:0] rd_data_i,
  input wire rd_valid_i,
  input wire rd_hit_i
);
  initial begin
    {wr_en_o, rd_en_o, wr_addr_o, rd_addr_o, wr_data_o} = '0;
  end
  // only words the test commands
  // Released lines show the inverse so stale values cannot pass
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_en_o <= 1'b1;
    wr_addr_o <= a;
    wr_data_o <= d;
    @(posedge clk_i);
    wr_en_o <= 1'b0;
    wr_addr_o <= ~a;
    wr_data_o <= ~d;
    #1;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d, output logic h, output logic v);
    @(posedge clk_i);
    rd_en_o <= 1'b1;
    rd_addr_o <= a;
    @(posedge clk_i);
    rd_en_o <= 1'b0;
    rd_addr_o <= ~a;
    #1;
    d = rd_data_i;
    h = rd_hit_i;
    v = rd_valid_i;
  endtask
endmodule

// >>> verif/test_initial_speed_detect_config.sv
// Self-checking bench for the configuration word.
// Assumes the host model drives every request of the block.
`timescale 1ns/1ps
module test_initial_speed_detect_config;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  int num_errors = 0;
  int comparisons = 0;
  wire w_e, r_e, r_v, r_h;
  wire [7:0] w_a, r_a;
  wire [31:0] w_d, r_d;
  int kdur[16] = '{10, 50, 100, 200, 300, 400, 500, 750, 1000, 2000, 3000, 4000, 5000,
    7500, 10000, 15000};
  int kmv[8] = '{50, 75, 100, 250, 500, 750, 1000, 1500};
  int khs[16] = '{25, 50, 75, 100, 125, 150, 200, 250, 300, 400, 500, 600, 700, 800,
    900, 1000};
  int krc[4] = '{15, 25, 35, 50};
  int kbc[8] = '{1, 2, 3, 5, 10, 20, 40, 0};
  always #2 clk_i = ~clk_i;
  serial_host_model serial_host_model_inst (.clk_i(clk_i), .wr_en_o(w_e), .wr_addr_o(w_a),
    .wr_data_o(w_d), .rd_en_o(r_e), .rd_addr_o(r_a), .rd_data_i(r_d), .rd_valid_i(r_v),
    .rd_hit_i(r_h));
  initial_speed_detect_config initial_speed_detect_config_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wr_en_i(w_e), .wr_addr_i(w_a), .wr_data_i(w_d), .rd_en_i(r_e), .rd_addr_i(r_a),
    .rd_data_o(r_d), .rd_valid_o(r_v), .rd_hit_o(r_h), .config_word_o(), .detect_en_o(),
    .brake_en_o(), .coast_en_o(), .reverse_en_o(), .resync_en_o(),
    .forward_resync_speed_threshold_o(), .brake_style_select_o(), .brake_exit_condition_o(),
    .brake_current_threshold_o(), .brake_duration_o(), .coast_duration_o(),
    .stationary_backemf_threshold_o(), .reverse_handoff_speed_o(),
    .reverse_open_loop_current_limit_o(), .resync_speed_permille_o(),
    .brake_exit_uses_current_o(), .brake_current_sixteenths_o(), .brake_duration_ms_o(),
    .coast_duration_ms_o(), .stationary_backemf_mv_o(), .handoff_speed_permille_o(),
    .reverse_current_sixteenths_o(), .reserved_setting_o());
  `define D test_initial_speed_detect_config.initial_speed_detect_config_inst
  // Wide enough for a read word plus its hit and valid flags
  task chk(input logic [33:0] got, input logic [33:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task final_report;
    if (num_errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Watchdog well beyond the roughly 80 cycles of the run
  initial begin
    repeat (5000) @(posedge clk_i);
    num_errors++;
    final_report;
  end
  initial begin
    logic [31:0] d, w;
    logic h, v;
    logic [3:0] k;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    serial_host_model_inst.rd(8'h80, d, h, v);
    chk({d, h, v}, {32'h0, 2'b11});
    chk(`D.reserved_setting_o, 1);
    // Every code of every multi-bit field, coast run backwards against brake
    for (int c = 0; c < 16; c++) begin
      k = c;
      w = {1'b0, 5'(k) ^ 5'h15, k, 1'b1, k[0], k[2:0], k, ~k, k[2:0], k, k[1:0]};
      serial_host_model_inst.wr(8'h80, w);
      chk(`D.config_word_o, w);
      chk({`D.detect_en_o, `D.brake_en_o, `D.coast_en_o, `D.reverse_en_o, `D.resync_en_o},
        w[30:26]);
      chk({`D.forward_resync_speed_threshold_o, `D.brake_style_select_o,
        `D.brake_exit_condition_o, `D.brake_current_threshold_o, `D.brake_duration_o,
        `D.coast_duration_o, `D.stationary_backemf_threshold_o, `D.reverse_handoff_speed_o,
        `D.reverse_open_loop_current_limit_o}, w[25:0]);
      chk(`D.resync_speed_permille_o, c < 12 ? 50 * (c + 1) : 700 + 100 * (c - 12));
      chk(`D.brake_style_select_o, 1);
      chk(`D.brake_exit_uses_current_o, k[0]);
      chk(`D.brake_current_sixteenths_o, kbc[k[2:0]]);
      chk(`D.reserved_setting_o, k[2:0] == 3'h7);
      chk(`D.brake_duration_ms_o, kdur[c]);
      chk(`D.coast_duration_ms_o, kdur[15 - c]);
      chk(`D.stationary_backemf_mv_o, kmv[k[2:0]]);
      chk(`D.handoff_speed_permille_o, khs[c]);
      chk(`D.reverse_current_sixteenths_o, krc[k[1:0]]);
      serial_host_model_inst.rd(8'h80, d, h, v);
      chk({d, h, v}, {w, 2'b11});
    end
    // Top bit is read-only; all-ones also lands on the reserved brake current code
    serial_host_model_inst.wr(8'h80, 32'hFFFFFFFF);
    serial_host_model_inst.rd(8'h80, d, h, v);
    chk(d, 32'h7FFFFFFF);
    chk(`D.reserved_setting_o, 1);
    // Neighbouring offset is not this word
    serial_host_model_inst.wr(8'h82, 32'h0);
    chk(`D.config_word_o, 32'h7FFFFFFF);
    serial_host_model_inst.rd(8'h82, d, h, v);
    chk({d, h, v}, {32'h0, 2'b01});
    final_report;
  end
endmodule
